// *** rtl/dsp_regs.svh ***
`ifndef DSP_REGS_SVH
`define DSP_REGS_SVH
`define DSP_OFS_SRC_SIZE 8'h00
`define DSP_OFS_DST_SIZE 8'h04
`define DSP_OFS_SRC_PTR  8'h08
`define DSP_OFS_DST_PTR  8'h0C
`define DSP_OFS_CTRL     8'h10
`define DSP_OFS_STATUS   8'h14
`define DSP_OFS_CLEAR    8'h18
`define DSP_OFS_ENABLE   8'h1C
`define DSP_CTRL_PATTERN 0
`define DSP_CTRL_RESTART 1
`define DSP_ST_HALF      0
`define DSP_ST_DONE      1
`define DSP_ST_WIDTH     2
`define DSP_RST_SIZE     16'h0000
`define DSP_RESP_OKAY    2'h0
`define DSP_RESP_SLVERR  2'h2
`endif

// *** rtl/dsp_pkg.sv ***
package dsp_pkg;
	typedef logic [15:0] dsp_count_t;
	typedef enum logic [1:0]
	{
		DSP_IDLE = 2'h0,
		DSP_RESP = 2'h1
	} dsp_bus_e;
endpackage

// *** rtl/dsp_ptr.sv ***
`timescale 1ns/100ps
module dsp_ptr
	import dsp_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       clr,
	input  wire logic       step,
	input  wire logic [2:0] step_bytes,
	input  wire dsp_count_t limit,
	output dsp_count_t      ptr_reg,
	output logic            wrap
);
	logic [16:0] sum;
	always_comb
	begin
		sum = {1'b0, ptr_reg} + {14'h0000, step_bytes};
		// size zero treated as full 64K range
		wrap = step && (limit != 16'h0000) && (sum >= {1'b0, limit});
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clr)
			ptr_reg <= 16'h0000;
		else if (wrap)
			ptr_reg <= 16'h0000;
		else if (step)
			ptr_reg <= sum[15:0];
	end
endmodule

// *** rtl/dsp_channel.sv ***
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "dsp_regs.svh"
module dsp_channel
	import dsp_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        src_beat,
	input  wire logic [2:0]  src_beat_bytes,
	input  wire logic        dst_beat,
	input  wire logic [2:0]  dst_beat_bytes,
	input  wire logic        pattern_hit,
	output logic             pattern_mode_reg,
	output logic             dst_half_full_flag,
	output logic             block_done_flag,
	output logic             irq_reg
);
	dsp_count_t              src_buffer_length;
	dsp_count_t              dst_buffer_length;
	dsp_count_t              src_byte_index;
	dsp_count_t              dst_byte_index;
	logic [`DSP_ST_WIDTH-1:0] status_reg;
	logic [`DSP_ST_WIDTH-1:0] enable_reg;
	logic [`DSP_ST_WIDTH-1:0] clear_pulse;
	logic [`DSP_ST_WIDTH-1:0] event_set;
	logic [16:0]             total_reg;
	logic [16:0]             total_next;
	dsp_count_t              larger;
	logic                    restart;
	logic                    pattern_clear;
	logic                    src_wrap;
	logic                    dst_wrap;
	logic                    half_hit;
	logic                    done_hit;
	logic                    aw_held;
	logic                    w_held;
	logic [7:0]              aw_addr_reg;
	logic [31:0]             w_data_reg;
	logic [3:0]              w_strb_reg;
	logic                    do_write;
	logic [7:0]              wr_addr;
	logic [31:0]             wr_data;
	logic [3:0]              wr_strb;
	logic                    wr_hit;
	logic [31:0]             rd_word;
	logic                    rd_hit;
	dsp_bus_e                wstate;
	dsp_bus_e                rstate;

	// write channel: address and data in either order
	assign wr_addr  = aw_held ? aw_addr_reg : s_axi_awaddr;
	assign wr_data  = w_held ? w_data_reg : s_axi_wdata;
	assign wr_strb  = w_held ? w_strb_reg : s_axi_wstrb;
	assign do_write = (wstate == DSP_IDLE)
		&& (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h00000000;
			w_strb_reg    <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `DSP_RESP_OKAY;
			wstate        <= DSP_IDLE;
		end
		else
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			case (wstate)
				DSP_IDLE:
				begin
					if (do_write)
					begin
						aw_held      <= 1'b0;
						w_held       <= 1'b0;
						s_axi_awready <= !aw_held;
						s_axi_wready  <= !w_held;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= wr_hit ? `DSP_RESP_OKAY
							: `DSP_RESP_SLVERR;
						wstate       <= DSP_RESP;
					end
					else if (s_axi_awvalid && !aw_held)
					begin
						aw_held       <= 1'b1;
						aw_addr_reg   <= s_axi_awaddr;
						s_axi_awready <= 1'b1;
					end
					else if (s_axi_wvalid && !w_held)
					begin
						w_held       <= 1'b1;
						w_data_reg   <= s_axi_wdata;
						w_strb_reg   <= s_axi_wstrb;
						s_axi_wready <= 1'b1;
					end
				end
				default:
				begin
					if (s_axi_bready)
					begin
						s_axi_bvalid <= 1'b0;
						wstate       <= DSP_IDLE;
					end
				end
			endcase
		end
	end

	always_comb
	begin
		wr_hit = 1'b1;
		if (wr_addr == `DSP_OFS_SRC_SIZE)
			wr_hit = 1'b1;
		else if (wr_addr == `DSP_OFS_DST_SIZE)
			wr_hit = 1'b1;
		else if (wr_addr == `DSP_OFS_CTRL)
			wr_hit = 1'b1;
		else if (wr_addr == `DSP_OFS_CLEAR)
			wr_hit = 1'b1;
		else if (wr_addr == `DSP_OFS_ENABLE)
			wr_hit = 1'b1;
		else if (wr_addr == `DSP_OFS_SRC_PTR || wr_addr == `DSP_OFS_DST_PTR
			|| wr_addr == `DSP_OFS_STATUS)
			wr_hit = 1'b1; // read-only: write ignored
		else
			wr_hit = 1'b0;
	end

	// sizes take low two byte lanes only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			src_buffer_length <= `DSP_RST_SIZE;
			dst_buffer_length <= `DSP_RST_SIZE;
			pattern_mode_reg  <= 1'b0;
			enable_reg        <= '0;
		end
		else if (do_write)
		begin
			if (wr_addr == `DSP_OFS_SRC_SIZE)
			begin
				if (wr_strb[0])
					src_buffer_length[7:0] <= wr_data[7:0];
				if (wr_strb[1])
					src_buffer_length[15:8] <= wr_data[15:8];
			end
			else if (wr_addr == `DSP_OFS_DST_SIZE)
			begin
				if (wr_strb[0])
					dst_buffer_length[7:0] <= wr_data[7:0];
				if (wr_strb[1])
					dst_buffer_length[15:8] <= wr_data[15:8];
			end
			else if (wr_addr == `DSP_OFS_CTRL && wr_strb[0])
				pattern_mode_reg <= wr_data[`DSP_CTRL_PATTERN];
			else if (wr_addr == `DSP_OFS_ENABLE && wr_strb[0])
				enable_reg <= wr_data[`DSP_ST_WIDTH-1:0];
		end
	end

	assign restart = do_write && wr_addr == `DSP_OFS_CTRL && wr_strb[0]
		&& wr_data[`DSP_CTRL_RESTART];
	assign clear_pulse = (do_write && wr_addr == `DSP_OFS_CLEAR
		&& wr_strb[0]) ? wr_data[`DSP_ST_WIDTH-1:0] : '0;
	assign pattern_clear = pattern_mode_reg && pattern_hit;

	dsp_ptr u_src_ptr
	(
		.aclk       (aclk),
		.aresetn    (aresetn),
		.clr        (restart || pattern_clear),
		.step       (src_beat),
		.step_bytes (src_beat_bytes),
		.limit      (src_buffer_length),
		.ptr_reg    (src_byte_index),
		.wrap       (src_wrap)
	);

	dsp_ptr u_dst_ptr
	(
		.aclk       (aclk),
		.aresetn    (aresetn),
		.clr        (restart),
		.step       (dst_beat),
		.step_bytes (dst_beat_bytes),
		.limit      (dst_buffer_length),
		.ptr_reg    (dst_byte_index),
		.wrap       (dst_wrap)
	);

	// block progress counted on the side with the larger size
	always_comb
	begin
		larger = (src_buffer_length >= dst_buffer_length)
			? src_buffer_length : dst_buffer_length;
		total_next = total_reg;
		if (src_buffer_length >= dst_buffer_length ? src_beat : dst_beat)
			total_next = total_reg + {14'h0000,
				(src_buffer_length >= dst_buffer_length)
				? src_beat_bytes : dst_beat_bytes};
		done_hit = ((larger != 16'h0000) && (total_next >= {1'b0, larger})
			&& (total_reg < {1'b0, larger})) || pattern_clear;
		// compare the index after this beat against half the size
		half_hit = dst_beat && !dst_wrap
			&& (dst_byte_index + {13'h0000, dst_beat_bytes}
			== {1'b0, dst_buffer_length[15:1]});
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || restart || done_hit)
			total_reg <= 17'h00000;
		else
			total_reg <= total_next;
	end

	assign event_set[`DSP_ST_HALF] = half_hit;
	assign event_set[`DSP_ST_DONE] = done_hit;

	// set wins over a clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			status_reg <= '0;
		else
			status_reg <= (status_reg & ~clear_pulse) | event_set;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_reg            <= 1'b0;
			dst_half_full_flag <= 1'b0;
			block_done_flag    <= 1'b0;
		end
		else
		begin
			irq_reg <= |(((status_reg & ~clear_pulse) | event_set)
				& enable_reg);
			dst_half_full_flag <= half_hit | (status_reg[`DSP_ST_HALF]
				& ~clear_pulse[`DSP_ST_HALF]);
			block_done_flag <= done_hit | (status_reg[`DSP_ST_DONE]
				& ~clear_pulse[`DSP_ST_DONE]);
		end
	end

	// upper half of every register reads zero
	always_comb
	begin
		rd_word = 32'h00000000;
		rd_hit  = 1'b1;
		if (s_axi_araddr == `DSP_OFS_SRC_SIZE)
			rd_word = {16'h0000, src_buffer_length};
		else if (s_axi_araddr == `DSP_OFS_DST_SIZE)
			rd_word = {16'h0000, dst_buffer_length};
		else if (s_axi_araddr == `DSP_OFS_SRC_PTR)
			rd_word = {16'h0000, src_byte_index};
		else if (s_axi_araddr == `DSP_OFS_DST_PTR)
			rd_word = {16'h0000, dst_byte_index};
		else if (s_axi_araddr == `DSP_OFS_CTRL)
			rd_word = {31'h00000000, pattern_mode_reg};
		else if (s_axi_araddr == `DSP_OFS_STATUS)
			rd_word = {30'h00000000, status_reg};
		else if (s_axi_araddr == `DSP_OFS_ENABLE)
			rd_word = {30'h00000000, enable_reg};
		else if (s_axi_araddr == `DSP_OFS_CLEAR)
			rd_word = 32'h00000000;
		else
			rd_hit = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `DSP_RESP_OKAY;
			rstate        <= DSP_IDLE;
		end
		else
		begin
			s_axi_arready <= 1'b0;
			case (rstate)
				DSP_IDLE:
				begin
					if (s_axi_arvalid)
					begin
						s_axi_arready <= 1'b1;
						s_axi_rvalid  <= 1'b1;
						s_axi_rdata   <= rd_word;
						s_axi_rresp   <= rd_hit ? `DSP_RESP_OKAY
							: `DSP_RESP_SLVERR;
						rstate        <= DSP_RESP;
					end
				end
				default:
				begin
					if (s_axi_rready)
					begin
						s_axi_rvalid <= 1'b0;
						rstate       <= DSP_IDLE;
					end
				end
			endcase
		end
	end
endmodule

// *** testbench/dsp_channel_monitor.sv ***
`timescale 1ns/100ps
module dsp_channel_monitor
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        src_beat,
	input wire logic        dst_beat,
	input wire logic        pattern_hit,
	input wire logic        pattern_mode_reg,
	input wire logic        dst_half_full_flag,
	input wire logic        block_done_flag,
	input wire logic        irq_reg
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_rdata_upper_zero: assert property (s_axi_rvalid |->
		s_axi_rdata[31:16] == 16'h0000) else $error("upper read bits set");
	a_half_from_dst: assert property ($rose(dst_half_full_flag) |->
		$past(dst_beat)) else $error("half flag without dst beat");
	a_done_has_cause: assert property ($rose(block_done_flag) |->
		$past(src_beat | dst_beat | pattern_hit))
		else $error("done flag without cause");
	a_pattern_sets_done: assert property (
		pattern_hit && pattern_mode_reg |-> ##1 block_done_flag)
		else $error("pattern hit did not set done");
	a_irq_needs_flag: assert property (irq_reg |->
		dst_half_full_flag || block_done_flag) else $error("stray irq");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid &&
		!s_axi_bvalid |=> s_axi_bvalid) else $error("write not answered");
	c_irq: cover property ($rose(irq_reg));
	c_half: cover property ($rose(dst_half_full_flag));
	c_pattern: cover property (pattern_hit && pattern_mode_reg);
endmodule
bind dsp_channel dsp_channel_monitor dsp_channel_monitor_i (.*);

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
`include "dsp_regs.svh"
module testbench
	import dsp_pkg::*;
;
	localparam logic [1:0] OK = `DSP_RESP_OKAY;
	localparam logic [1:0] ER = `DSP_RESP_SLVERR;
	logic        aclk = '0, aresetn = '0, s_axi_awvalid = '0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, r;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [2:0]  src_beat_bytes = 3'h1, dst_beat_bytes = 3'h1;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
	logic        s_axi_rready = '0, src_beat = '0, dst_beat = '0;
	logic        pattern_hit = '0, s_axi_awready, s_axi_wready, hf, dn;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_reg;
	logic        pattern_mode_reg, dst_half_full_flag, block_done_flag;
	dsp_count_t  sp, dp, sz;
	int          i, seed = 55073, bad_count = 0, tests_run = 0;
	dsp_channel dsp_channel_i (.*);
	always #5 aclk = ~aclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// hold each valid until its own ready, bounded wait
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		// some addresses hold off bready so bvalid must stand
		s_axi_bready <= a[2];
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1 && s_axi_bready !== 1'h1)
				s_axi_bready <= 1'h1;
		end
		while ((s_axi_bvalid & s_axi_bready) !== 1'h1 && n < 99);
		s_axi_bready <= 1'h0;
		chk(s_axi_bvalid, 1'h1);
		chk(s_axi_bresp, er);
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ex,
		input logic [1:0] er);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= a[2];
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1 && s_axi_rready !== 1'h1)
				s_axi_rready <= 1'h1;
		end
		while ((s_axi_rvalid & s_axi_rready) !== 1'h1 && n < 99);
		s_axi_rready <= 1'h0;
		chk(s_axi_rvalid, 1'h1);
		chk(s_axi_rdata, ex);
		chk(s_axi_rresp, er);
		@(posedge aclk);
	endtask
	task automatic drv(input logic s, dd, p, input logic [2:0] nb);
		src_beat <= s;
		dst_beat <= dd;
		src_beat_bytes <= nb;
		dst_beat_bytes <= nb;
		pattern_hit <= p;
		@(posedge aclk);
	endtask
	// size zero wraps at the full 16-bit range
	function automatic dsp_count_t nxt(dsp_count_t p, s, logic [2:0] b);
		logic [16:0] t;
		t = p + b;
		return (s != 16'h0000 && t >= s) ? 16'h0000 : t[15:0];
	endfunction
	initial
	begin
		#200000;
		bad_count++;
		conclude();
	end
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		for (i = 0; i < 4; i++)
			rd(8'(i * 4), 32'h0, OK);
		$display("test reset values done");
		for (i = 0; i < 6; i++)
		begin
			d = i ? $random(seed) : 32'hFFFFFFFF;
			wr({5'h00, i[0], 2'h0}, d, OK);
			rd({5'h00, i[0], 2'h0}, {16'h0000, d[15:0]}, OK);
		end
		wr(`DSP_OFS_SRC_PTR, 32'h1234, OK);
		rd(`DSP_OFS_SRC_PTR, 32'h0, OK);
		wr(8'h20, 32'h1, ER);
		rd(8'h20, 32'h0, ER);
		wr(`DSP_OFS_SRC_SIZE, 32'h00001234, OK);
		s_axi_wstrb <= 4'h2;
		wr(`DSP_OFS_SRC_SIZE, 32'h0000AB00, OK);
		s_axi_wstrb <= 4'hF;
		rd(`DSP_OFS_SRC_SIZE, 32'h0000AB34, OK);
		$display("test registers done");
		wr(`DSP_OFS_CTRL, 32'h2, OK);
		wr(`DSP_OFS_SRC_SIZE, 32'h6, OK);
		wr(`DSP_OFS_DST_SIZE, 32'h8, OK);
		wr(`DSP_OFS_ENABLE, 32'h3, OK);
		{hf, dn, dp} = '0;
		for (i = 0; i < 4; i++)
		begin
			drv(1'h0, 1'h1, 1'h0, 3'h2);
			drv(1'h0, 1'h0, 1'h0, 3'h1);
			dp = nxt(dp, 16'h0008, 3'h2);
			hf |= dp == 16'h0004;
			dn |= i == 3;
			rd(`DSP_OFS_DST_PTR, {16'h0000, dp}, OK);
			chk(dst_half_full_flag, hf);
			chk(block_done_flag, dn);
			chk(irq_reg, hf | dn);
		end
		wr(`DSP_OFS_ENABLE, 32'h0, OK);
		drv(1'h0, 1'h0, 1'h0, 3'h1);
		chk(irq_reg, 1'h0);
		wr(`DSP_OFS_CLEAR, 32'h3, OK);
		drv(1'h0, 1'h0, 1'h0, 3'h1);
		chk({dst_half_full_flag, block_done_flag}, 2'h0);
		wr(`DSP_OFS_ENABLE, 32'h3, OK);
		$display("test flags done");
		r = $random(seed);
		sz = 16'(r[4:0]) + 16'h0008;
		wr(`DSP_OFS_SRC_SIZE, {16'h0000, sz}, OK);
		sp = '0;
		for (i = 0; i < 12; i++)
		begin
			r = $random(seed);
			drv(1'h1, 1'h0, r[4], r[1:0] + 3'h1);
			drv(1'h0, 1'h0, 1'h0, 3'h1);
			sp = nxt(sp, sz, r[1:0] + 3'h1);
			rd(`DSP_OFS_SRC_PTR, {16'h0000, sp}, OK);
		end
		$display("test source walk done");
		// restart clears the counters so only the hit can raise done
		wr(`DSP_OFS_CTRL, 32'h3, OK);
		wr(`DSP_OFS_CLEAR, 32'h3, OK);
		chk(pattern_mode_reg, 1'h1);
		drv(1'h1, 1'h0, 1'h0, 3'h3);
		drv(1'h0, 1'h0, 1'h0, 3'h1);
		rd(`DSP_OFS_SRC_PTR, 32'h3, OK);
		chk(block_done_flag, 1'h0);
		drv(1'h0, 1'h0, 1'h1, 3'h1);
		drv(1'h0, 1'h0, 1'h0, 3'h1);
		rd(`DSP_OFS_SRC_PTR, 32'h0, OK);
		chk(block_done_flag, 1'h1);
		$display("test pattern done");
		conclude();
	end
endmodule
